// >>> hdl/smpg_defs.svh
// Addresses, limits, reset values and timing of the profile generator
`ifndef SMPG_DEFS_SVH
`define SMPG_DEFS_SVH
`define SMPG_ADDR_SPD_LIMIT  16'h0612
`define SMPG_ADDR_ACCEL      16'h0614
`define SMPG_ADDR_DECEL      16'h0616
`define SMPG_ADDR_JERK       16'h061a
`define SMPG_ADDR_START_STOP 16'h0622
`define SMPG_ADDR_SHAPE      16'h0626
`define SMPG_SPD_LIMIT_MIN   32'h0000_003c
`define SMPG_SPD_LIMIT_MAX   32'h0000_0bb8
`define SMPG_ACCEL_MIN       32'h0000_0001
`define SMPG_DECEL_MIN       32'h0000_00c8
`define SMPG_RAMP_MAX        32'h002d_c6c0
`define SMPG_RAMP_RED_SHIFT  2
`define SMPG_START_STOP_NOM  16'h003c
`define SMPG_JERK_MAX        32'h0000_0080
`define SMPG_SHAPE_OPT       16'hffff
`define SMPG_SHAPE_LINEAR    16'h0000
`define SMPG_RST_SPD_LIMIT   16'(`SMPG_SPD_LIMIT_MAX)
`define SMPG_RST_ACCEL       32'h0000_0258
`define SMPG_RST_DECEL       32'h0000_02ee
`define SMPG_RST_JERK        16'h0000
`define SMPG_RST_START_STOP  16'h001e
`define SMPG_OPT_TIER1       32'h0007_d000
`define SMPG_OPT_TIER2       32'h000f_a000
`define SMPG_OPT_TIER3       32'h001f_4000
`define SMPG_MILLI           32'h0000_03e8
`define SMPG_TICK_MS         1
`define SMPG_CLK_KHZ         50000
`define SMPG_TICK_CYCLES     (`SMPG_TICK_MS * `SMPG_CLK_KHZ)
`define SMPG_POS_W           40
`endif

// >>> hdl/smpg_jerk_filter.sv
// Moving-average jerk filter on the unfiltered reference speed
module smpg_jerk_filter #(
  parameter int unsigned W     = 32,
  parameter int unsigned DEPTH = 128
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         sampleEn,
  input  wire logic         clear,
  input  wire logic         enable,
  input  wire logic [2:0]   shiftSel,
  input  wire logic [W-1:0] sampleIn,
  output logic      [W-1:0] sampleOut,
  output logic              settled
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned SW = W + 8;

  if (DEPTH < 128 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two of at least 128");
  end

  logic [W-1:0]  hist [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [SW-1:0] sum_r;
  logic [SW-1:0] sum_nxt;
  logic [W-1:0]  out_nxt;
  logic [AW-1:0] oldIdx;

  // Window of 2**shiftSel samples; the oldest one leaves the sum
  assign oldIdx  = wrPtr_r - AW'(8'h01 << shiftSel);
  assign sum_nxt = sum_r + SW'(sampleIn) - SW'(hist[oldIdx]);
  assign out_nxt = enable ? W'(sum_nxt >> shiftSel) : sampleIn;

  always_ff @(posedge core_clk) begin
    if (srst || clear) begin
      for (int i = 0; i < DEPTH; i++) begin
        hist[i] <= '0;
      end
      wrPtr_r <= '0;
      sum_r   <= '0;
    end else if (sampleEn) begin
      hist[wrPtr_r] <= sampleIn;
      wrPtr_r       <= wrPtr_r + AW'(1);
      sum_r         <= sum_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sampleOut <= '0;
      settled   <= 1'b1;
    end else if (sampleEn) begin
      sampleOut <= out_nxt;
      settled   <= (out_nxt == '0) && (sum_nxt == '0);
    end
  end
endmodule : smpg_jerk_filter

// >>> hdl/smpg_pkg.sv
// Types shared by the profile generator modules
`include "smpg_defs.svh"
package smpg_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_ACCEL  = 2'h1,
    ST_CRUISE = 2'h3,
    ST_DECEL  = 2'h2
  } smpg_state_t;

  typedef enum logic [2:0] {
    MODE_NONE     = 3'h0,
    MODE_PROF_POS = 3'h1,
    MODE_PROF_VEL = 3'h2,
    MODE_HOMING   = 3'h3,
    MODE_JOG      = 3'h4
  } smpg_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wrData;
    logic        wr;
    logic        rd;
  } smpg_param_req_t;

  typedef struct packed {
    logic signed [`SMPG_POS_W-1:0] targetPos;
    logic signed [15:0]            targetSpeed;
    smpg_mode_t                    mode;
    logic                          start;
    logic                          quickStop;
  } smpg_move_cmd_t;
endpackage : smpg_pkg

// >>> hdl/smpg_profile_gen.sv
// Motion profile generator: parameter set, ramp engine, end-of-move flag
//
// How it works
// - Profile comes from target position and speed per selected mode.
// - Shape select -1 gives motor-optimised ramp, 0 gives linear ramp.
// - Quick stop always decelerates along the linear ramp.
// - Ramp settings act the same in both rotation directions.
// - Motor-optimised ramp lowers acceleration as speed rises.
// - Every profile starts and ends at the start/stop speed, or at the target speed if that is lower.
// - Start/stop speed above nominal reduces acceptable ramp values.
// - Separate steepness for acceleration and deceleration ramps.
// - Acceleration is 32-bit, 1 to 3000000 rpm/s, reset 600.
// - Deceleration is 32-bit, 200 to 3000000 rpm/s, reset 750.
// - Requested speed is clamped to the speed limit, 60 to 3000.
// - Jerk code 0 is off, else 1 to 128 ms in powers of two.
// - Jerk filter acts in all four profile modes.
// - Move complete only after the filtered trajectory has ended.
// - Jerk setting writes are refused unless move complete is set.
`include "smpg_defs.svh"

module smpg_profile_gen #(
  parameter int unsigned TICK_CYCLES = `SMPG_TICK_CYCLES,
  parameter int unsigned FILT_DEPTH  = 128
) (
  input  wire smpg_pkg::smpg_param_req_t paramReq,
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  output logic [31:0]                    paramRdData,
  output logic                           paramAck,
  output logic                           paramErr,
  input  wire smpg_pkg::smpg_move_cmd_t  moveCmd,
  output logic signed [31:0]             refSpeed,
  output smpg_pkg::smpg_state_t          profilePhase,
  output logic                           motionComplete
);
  localparam int unsigned TW = $clog2(TICK_CYCLES);
  localparam int unsigned PW = `SMPG_POS_W;
  localparam logic [31:0] MILLI = `SMPG_MILLI;

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  function automatic logic inRange(input logic [31:0] v,
                                   input logic [31:0] lo,
                                   input logic [31:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : inRange

  function automatic logic [31:0] optRate(input logic [31:0] rate,
                                          input logic [31:0] spd);
    logic [31:0] r;
    r = rate;
    if (spd >= `SMPG_OPT_TIER3) begin
      r = rate - (rate >> 1);
    end else if (spd >= `SMPG_OPT_TIER2) begin
      r = rate - (rate >> 2);
    end else if (spd >= `SMPG_OPT_TIER1) begin
      r = rate - (rate >> 3);
    end
    return r;
  endfunction : optRate

  function automatic logic [31:0] umin(input logic [31:0] a,
                                       input logic [31:0] b);
    return (a < b) ? a : b;
  endfunction : umin

  function automatic logic [31:0] umax(input logic [31:0] a,
                                       input logic [31:0] b);
    return (a > b) ? a : b;
  endfunction : umax

  //////////////////////////////////////////////////////////////////////////
  // Parameter registers
  logic [15:0] spdLimit_r;
  logic [31:0] accel_r;
  logic [31:0] decel_r;
  logic [15:0] jerk_r;
  logic [15:0] startStop_r;
  logic [15:0] shape_r;
  logic [31:0] rdData_r;
  logic        ack_r;
  logic        err_r;
  logic        motionComplete_r;

  wire logic [31:0] wd = paramReq.wrData;
  wire logic        upZero = wd[31:16] == 16'h0000;
  wire logic selLim   = paramReq.addr == `SMPG_ADDR_SPD_LIMIT;
  wire logic selAcc   = paramReq.addr == `SMPG_ADDR_ACCEL;
  wire logic selDec   = paramReq.addr == `SMPG_ADDR_DECEL;
  wire logic selJerk  = paramReq.addr == `SMPG_ADDR_JERK;
  wire logic selStart = paramReq.addr == `SMPG_ADDR_START_STOP;
  wire logic selShape = paramReq.addr == `SMPG_ADDR_SHAPE;
  wire logic mapped   = selLim | selAcc | selDec | selJerk | selStart
                        | selShape;

  // Too fast a start/stop speed narrows the ramp range
  wire logic [31:0] rampMax = (startStop_r > `SMPG_START_STOP_NOM)
    ? (`SMPG_RAMP_MAX >> `SMPG_RAMP_RED_SHIFT) : `SMPG_RAMP_MAX;

  wire logic okLim = inRange(wd, `SMPG_SPD_LIMIT_MIN,
                             `SMPG_SPD_LIMIT_MAX);
  wire logic okAcc = inRange(wd, `SMPG_ACCEL_MIN, rampMax);
  wire logic okDec = inRange(wd, `SMPG_DECEL_MIN, rampMax);
  wire logic okJerk = (wd <= `SMPG_JERK_MAX)
    && ((wd & (wd - 32'h1)) == 32'h0) && motionComplete_r;
  wire logic okShape = upZero && (wd[15:0] == `SMPG_SHAPE_OPT
    || wd[15:0] == `SMPG_SHAPE_LINEAR);
  wire logic wrOk = paramReq.wr && ((selLim && okLim)
    || (selAcc && okAcc) || (selDec && okDec) || (selJerk && okJerk)
    || (selStart && upZero) || (selShape && okShape));
  wire logic jerkWr = wrOk && selJerk;

  wire logic [31:0] rdMux =
      selLim   ? {16'h0000, spdLimit_r}
    : selAcc   ? accel_r
    : selDec   ? decel_r
    : selJerk  ? {16'h0000, jerk_r}
    : selStart ? {16'h0000, startStop_r}
    : selShape ? {16'h0000, shape_r}
    : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      spdLimit_r  <= `SMPG_RST_SPD_LIMIT;
      accel_r     <= `SMPG_RST_ACCEL;
      decel_r     <= `SMPG_RST_DECEL;
      jerk_r      <= `SMPG_RST_JERK;
      startStop_r <= `SMPG_RST_START_STOP;
      shape_r     <= `SMPG_SHAPE_LINEAR;
    end else if (wrOk) begin
      if (selLim) spdLimit_r <= wd[15:0];
      if (selAcc) accel_r <= wd;
      if (selDec) decel_r <= wd;
      if (selJerk) jerk_r <= wd[15:0];
      if (selStart) startStop_r <= wd[15:0];
      if (selShape) shape_r <= wd[15:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdData_r <= 32'h0000_0000;
      ack_r    <= 1'b0;
      err_r    <= 1'b0;
    end else begin
      rdData_r <= (paramReq.rd && mapped) ? rdMux : 32'h0000_0000;
      ack_r    <= paramReq.wr || paramReq.rd;
      err_r    <= (paramReq.rd && !mapped) || (paramReq.wr && !wrOk);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Millisecond profile tick
  logic [TW-1:0] tickCnt_r;
  logic          tick_r;
  wire logic tickWrap = tickCnt_r == TW'(TICK_CYCLES - 1);

  always_ff @(posedge core_clk) begin
    if (srst || tickWrap) tickCnt_r <= '0;
    else tickCnt_r <= tickCnt_r + TW'(1);
    tick_r <= !srst && tickWrap;
  end

  //////////////////////////////////////////////////////////////////////////
  // Ramp engine, speeds in milli-rpm, distance in speed-ticks
  smpg_pkg::smpg_state_t state_r;
  smpg_pkg::smpg_state_t state_nxt;
  smpg_pkg::smpg_mode_t  mode_r;
  smpg_pkg::smpg_mode_t  mode_nxt;
  logic [31:0]   spd_r;
  logic [31:0]   spd_nxt;
  logic [31:0]   tgt_r;
  logic [31:0]   tgt_nxt;
  logic [PW-1:0] rem_r;
  logic [PW-1:0] rem_nxt;
  logic          dir_r;
  logic          dir_nxt;
  logic          pend_r;
  logic          pend_nxt;
  logic [31:0]   filtOut;
  logic          filtSettled;
  logic signed [31:0] refSpeed_r;

  wire logic qs = moveCmd.quickStop;
  wire logic cmdPv = moveCmd.mode == smpg_pkg::MODE_PROF_VEL;
  wire logic startTake = moveCmd.start
    && moveCmd.mode != smpg_pkg::MODE_NONE;
  wire logic [PW-1:0] absPos = moveCmd.targetPos[PW-1]
    ? PW'(-moveCmd.targetPos) : PW'(moveCmd.targetPos);
  wire logic [15:0] absSpd = moveCmd.targetSpeed[15]
    ? 16'(-moveCmd.targetSpeed) : 16'(moveCmd.targetSpeed);
  wire logic [15:0] clampSpd = (absSpd > spdLimit_r)
    ? spdLimit_r : absSpd;
  wire logic [31:0] tgtMilli = 32'(clampSpd) * MILLI;
  wire logic cmdDir = cmdPv ? moveCmd.targetSpeed[15]
    : moveCmd.targetPos[PW-1];

  wire logic posMove = mode_r != smpg_pkg::MODE_PROF_VEL;
  wire logic [31:0] vs = 32'(startStop_r) * MILLI;
  wire logic shapeOpt = (shape_r == `SMPG_SHAPE_OPT) && !qs;
  wire logic [31:0] accEff = shapeOpt ? optRate(accel_r, spd_r)
    : accel_r;
  wire logic [31:0] decEff = shapeOpt ? optRate(decel_r, spd_r)
    : decel_r;

  // Brake once the remaining distance fits a deceleration to vs
  wire logic [79:0] brakeLhs = 80'(decEff) * 80'(rem_r) * 80'(2);
  wire logic [79:0] brakeDyn = 80'(decEff) * 80'(spd_r) * 80'(2);
  wire logic [79:0] brakeRhs = (spd_r > vs)
    ? 80'(spd_r) * 80'(spd_r) - 80'(vs) * 80'(vs) + brakeDyn : brakeDyn;
  wire logic brake = posMove && (brakeLhs <= brakeRhs);
  wire logic stopReq = qs || (!posMove && tgt_r == 32'h0);
  wire logic [31:0] stepDown = (spd_r > decEff) ? spd_r - decEff : '0;

  wire logic [31:0] runCand =
      stopReq ? ((spd_r <= vs) ? 32'h0 : umax(stepDown, vs))
    : brake ? umax(stepDown, umin(vs, tgt_r))
    : (spd_r > tgt_r) ? umax(stepDown, tgt_r)
    : umin(spd_r + accEff, tgt_r);
  wire logic lastStep = posMove && (32'(rem_r) <= runCand)
    && (rem_r[PW-1:32] == '0);
  wire logic [31:0] runSpd = lastStep ? 32'(rem_r) : runCand;
  wire logic [31:0] firstCand = umin(vs, tgt_r);
  wire logic [31:0] firstSpd = (posMove && 32'(rem_r) <= firstCand
    && rem_r[PW-1:32] == '0) ? 32'(rem_r) : firstCand;
  wire smpg_pkg::smpg_state_t runState =
      (runSpd == 32'h0) ? smpg_pkg::ST_IDLE
    : (runSpd > spd_r) ? smpg_pkg::ST_ACCEL
    : (runSpd < spd_r) ? smpg_pkg::ST_DECEL
    : smpg_pkg::ST_CRUISE;

  always_comb begin
    state_nxt = state_r;
    mode_nxt  = mode_r;
    spd_nxt   = spd_r;
    tgt_nxt   = tgt_r;
    rem_nxt   = rem_r;
    dir_nxt   = dir_r;
    pend_nxt  = pend_r;
    if (startTake && state_r == smpg_pkg::ST_IDLE) begin
      pend_nxt = 1'b1;
      mode_nxt = moveCmd.mode;
      tgt_nxt  = tgtMilli;
      rem_nxt  = absPos;
      dir_nxt  = cmdDir;
    end else if (startTake && cmdPv && !posMove) begin
      tgt_nxt = tgtMilli;
    end
    if (tick_r) begin
      unique case (state_r)
        smpg_pkg::ST_IDLE: begin
          if (pend_r && filtSettled && !qs) begin
            pend_nxt  = 1'b0;
            spd_nxt   = firstSpd;
            rem_nxt   = posMove ? rem_r - PW'(firstSpd) : rem_r;
            state_nxt = (firstSpd == 32'h0) ? smpg_pkg::ST_IDLE
                                            : smpg_pkg::ST_ACCEL;
          end
        end
        smpg_pkg::ST_ACCEL, smpg_pkg::ST_CRUISE,
        smpg_pkg::ST_DECEL: begin
          spd_nxt   = runSpd;
          rem_nxt   = posMove ? rem_r - PW'(runSpd) : rem_r;
          state_nxt = runState;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= smpg_pkg::ST_IDLE;
      mode_r  <= smpg_pkg::MODE_NONE;
      spd_r   <= 32'h0;
      tgt_r   <= 32'h0;
      rem_r   <= '0;
      dir_r   <= 1'b0;
      pend_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mode_r  <= mode_nxt;
      spd_r   <= spd_nxt;
      tgt_r   <= tgt_nxt;
      rem_r   <= rem_nxt;
      dir_r   <= dir_nxt;
      pend_r  <= pend_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Jerk filter and outputs
  logic [2:0] jerkShift;
  always_comb begin
    jerkShift = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (jerk_r[i]) jerkShift = 3'(i);
    end
  end

  smpg_jerk_filter #(
    .W     (32),
    .DEPTH (FILT_DEPTH)
  ) u_jerk (
    .core_clk  (core_clk),
    .srst      (srst),
    .sampleEn  (tick_r),
    .clear     (jerkWr),
    .enable    ((jerk_r != 16'h0) && (mode_r != smpg_pkg::MODE_NONE)),
    .shiftSel  (jerkShift),
    .sampleIn  (spd_r),
    .sampleOut (filtOut),
    .settled   (filtSettled)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      refSpeed_r       <= 32'sh0;
      motionComplete_r <= 1'b1;
    end else begin
      refSpeed_r <= dir_r ? -$signed(filtOut) : $signed(filtOut);
      motionComplete_r <= (state_r == smpg_pkg::ST_IDLE) && !pend_r
        && filtSettled && !startTake;
    end
  end

  assign paramRdData    = rdData_r;
  assign paramAck       = ack_r;
  assign paramErr       = err_r;
  assign refSpeed       = refSpeed_r;
  assign profilePhase   = state_r;
  assign motionComplete = motionComplete_r;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_wr(logic [15:0] a);
    paramReq.wr && paramReq.addr == a;
  endsequence
  sequence s_run_tick;
    tick_r && state_r != smpg_pkg::ST_IDLE && !stopReq && !brake
      && !lastStep;
  endsequence

  a_accel_range: assert property (
    s_wr(`SMPG_ADDR_ACCEL) ##0 (wd == 32'h0)
      |=> paramErr && accel_r == $past(accel_r))
    else $error("acceleration write out of range was taken");
  a_decel_range: assert property (
    s_wr(`SMPG_ADDR_DECEL) ##0 (wd < `SMPG_DECEL_MIN)
      |=> paramErr && decel_r == $past(decel_r))
    else $error("deceleration write below minimum was taken");
  a_reduced_ramp: assert property (
    s_wr(`SMPG_ADDR_ACCEL) ##0 (startStop_r > `SMPG_START_STOP_NOM
      && wd > (`SMPG_RAMP_MAX >> `SMPG_RAMP_RED_SHIFT)) |=> paramErr)
    else $error("full ramp value taken with high start speed");
  a_jerk_locked: assert property (
    s_wr(`SMPG_ADDR_JERK) ##0 !motionComplete_r
      |=> paramErr && jerk_r == $past(jerk_r))
    else $error("jerk setting changed during a move");
  a_speed_clamp: assert property (
    $rose(pend_r) |-> tgt_r <= 32'(spdLimit_r) * MILLI)
    else $error("target speed above the speed limit");
  a_start_step: assert property (
    state_r == smpg_pkg::ST_IDLE ##1 state_r != smpg_pkg::ST_IDLE
      |-> spd_r <= vs && spd_r <= tgt_r)
    else $error("move did not start at the start/stop speed");
  a_linear_step: assert property (
    s_run_tick ##0 (shape_r == `SMPG_SHAPE_LINEAR && spd_r < tgt_r)
      |=> spd_r == umin($past(spd_r) + $past(accel_r), $past(tgt_r)))
    else $error("linear acceleration step wrong");
  a_opt_reduce: assert property (
    s_run_tick ##0 (shapeOpt && spd_r >= `SMPG_OPT_TIER1
      && spd_r < tgt_r) |=> spd_r <= $past(spd_r)
      + $past(accel_r) - ($past(accel_r) >> 3))
    else $error("motor-optimised ramp not reduced at speed");
  a_qs_linear: assert property (
    tick_r && qs && state_r != smpg_pkg::ST_IDLE
      && spd_r > vs + decel_r && !lastStep
      |=> spd_r == $past(spd_r) - $past(decel_r))
    else $error("quick stop did not use the linear ramp");
  a_end_vs: assert property (
    state_r != smpg_pkg::ST_IDLE ##1 state_r == smpg_pkg::ST_IDLE
      && !posMove |-> $past(spd_r) <= vs)
    else $error("velocity move left above start/stop speed");
  a_done_filtered: assert property (
    $rose(motionComplete_r) |-> $past(filtOut) == 32'h0
      && $past(state_r) == smpg_pkg::ST_IDLE)
    else $error("move complete before the filter settled");
endmodule : smpg_profile_gen

// >>> verification/smpg_drive_model.sv
// Far-side model: power stage integrating reference speed into travel
module smpg_drive_model (
  input  wire logic                core_clk,
  input  wire logic                srst,
  input  wire logic signed [31:0]  refSpeed,
  output logic signed [47:0]       travel_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sign of travel follows the sign of the commanded speed
  always_ff @(posedge core_clk) begin
    if (srst) travel_r <= '0;
    else travel_r <= travel_r + 48'(refSpeed);
  end
endmodule : smpg_drive_model

// >>> verification/test_stepper_motion_profile_generator.sv
// Self-checking bench of the profile generator
`include "smpg_defs.svh"
module test_stepper_motion_profile_generator;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic        err;
    logic        rd;
    logic [31:0] data;
  } smpg_note_t;
  logic                       core_clk = 1'b0;
  logic                       srst = 1'b1;
  smpg_pkg::smpg_param_req_t  paramReq = '0;
  smpg_pkg::smpg_move_cmd_t   moveCmd = '0;
  logic [31:0]                paramRdData;
  logic                       paramAck;
  logic                       paramErr;
  logic                       motionComplete;
  logic signed [31:0]         refSpeed;
  logic signed [31:0]         last;
  logic signed [31:0]         d;
  logic [31:0]                rv;
  smpg_pkg::smpg_state_t      profilePhase;
  logic signed [47:0]         travel_r;
  logic signed [47:0]         t0;
  smpg_note_t                 notes[$];
  int                         n_fail = 0;
  int                         n_compared = 0;
  int                         i;
  logic [15:0] ba[8] = '{`SMPG_ADDR_SPD_LIMIT, `SMPG_ADDR_SPD_LIMIT,
    `SMPG_ADDR_ACCEL, `SMPG_ADDR_ACCEL, `SMPG_ADDR_DECEL,
    `SMPG_ADDR_JERK, `SMPG_ADDR_SHAPE, 16'h0618};
  logic [31:0] bd[8] = '{32'h3b, 32'hbb9, 32'h0, 32'h2dc6c1, 32'hc7,
    32'h3, 32'h1, 32'h5};

  always #10 core_clk = ~core_clk;

  smpg_profile_gen #(.TICK_CYCLES(20), .FILT_DEPTH(128)) uut (
    .paramReq(paramReq), .core_clk(core_clk), .srst(srst),
    .paramRdData(paramRdData), .paramAck(paramAck), .paramErr(paramErr),
    .moveCmd(moveCmd), .refSpeed(refSpeed), .profilePhase(profilePhase),
    .motionComplete(motionComplete));
  smpg_drive_model far (.core_clk(core_clk), .srst(srst),
    .refSpeed(refSpeed), .travel_r(travel_r));

  ////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic check(logic [31:0] got, logic [31:0] exp, string msg);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s: got %h want %h", $time, msg, got, exp);
    end
  endtask : check

  // One register access; the expected answer is queued for the monitor
  task pa(logic [15:0] a, logic [31:0] dat, logic w, logic err,
          logic [31:0] exp);
    @(negedge core_clk);
    paramReq.addr = a;
    paramReq.wrData = dat;
    paramReq.wr = w;
    paramReq.rd = ~w;
    notes.push_back('{err, ~w, exp});
    @(negedge core_clk);
    paramReq.wr = 1'b0;
    paramReq.rd = 1'b0;
  endtask : pa

  task startMove(int spd);
    @(negedge core_clk);
    moveCmd.mode = smpg_pkg::MODE_PROF_VEL;
    moveCmd.targetSpeed = 16'(spd);
    moveCmd.start = 1'b1;
    @(negedge core_clk);
    moveCmd.start = 1'b0;
  endtask : startMove

  // Difference between two successive reference speed updates
  task nextStep(output logic signed [31:0] st);
    logic signed [31:0] a;
    a = refSpeed;
    for (i = 0; i < 100 && refSpeed === a; i++) @(negedge core_clk);
    a = refSpeed;
    for (i = 0; i < 100 && refSpeed === a; i++) @(negedge core_clk);
    st = refSpeed - a;
  endtask : nextStep

  task waitDone(int lim);
    for (i = 0; i < lim && motionComplete !== 1'b1; i++) @(negedge core_clk);
    check({31'h0, motionComplete}, 32'h1, "move complete");
    check(refSpeed, 32'h0, "speed at rest");
  endtask : waitDone

  ////////////////////////////////////////////////////////////////////////
  always @(negedge core_clk) begin
    smpg_note_t n;
    if (paramAck === 1'b1) begin
      n = notes.pop_front();
      check({31'h0, paramErr}, {31'h0, n.err}, "refusal flag");
      if (n.rd) check(paramRdData, n.data, "read data");
    end
  end

  initial begin
    #2000000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'ha486f11d));
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    pa(`SMPG_ADDR_SPD_LIMIT, 0, 0, 0, 32'hbb8);
    pa(`SMPG_ADDR_ACCEL, 0, 0, 0, 32'h258);
    pa(`SMPG_ADDR_DECEL, 0, 0, 0, 32'h2ee);
    pa(`SMPG_ADDR_JERK, 0, 0, 0, 32'h0);
    pa(`SMPG_ADDR_SHAPE, 0, 0, 0, 32'h0);
    $display("test reset_values done");
    for (int k = 0; k < 8; k++) pa(ba[k], bd[k], 1, 1, 0);
    pa(`SMPG_ADDR_ACCEL, 0, 0, 0, 32'h258);
    pa(`SMPG_ADDR_ACCEL, 32'h2dc6c0, 1, 0, 0);
    pa(`SMPG_ADDR_DECEL, 32'hc8, 1, 0, 0);
    pa(`SMPG_ADDR_START_STOP, 32'h3d, 1, 0, 0);
    pa(`SMPG_ADDR_ACCEL, 32'h2dc6c0, 1, 1, 0);
    pa(`SMPG_ADDR_ACCEL, 32'hb71b0, 1, 0, 0);
    pa(`SMPG_ADDR_START_STOP, 32'h1e, 1, 0, 0);
    pa(`SMPG_ADDR_START_STOP, 0, 0, 0, 32'h1e);
    rv = $urandom_range(3000000, 1);
    pa(`SMPG_ADDR_ACCEL, rv, 1, 0, 0);
    pa(`SMPG_ADDR_ACCEL, 0, 0, 0, rv);
    for (int k = 0; k < 9; k++) begin
      rv = (k == 0) ? 32'h0 : 32'h1 << (k - 1);
      pa(`SMPG_ADDR_JERK, rv, 1, 0, 0);
      pa(`SMPG_ADDR_JERK, 0, 0, 0, rv);
    end
    pa(`SMPG_ADDR_SHAPE, 32'hffff, 1, 0, 0);
    pa(`SMPG_ADDR_SHAPE, 0, 0, 0, 32'hffff);
    pa(`SMPG_ADDR_SHAPE, 32'h0, 1, 0, 0);
    pa(`SMPG_ADDR_JERK, 32'h0, 1, 0, 0);
    pa(`SMPG_ADDR_ACCEL, 32'h258, 1, 0, 0);
    pa(`SMPG_ADDR_DECEL, 32'h2ee, 1, 0, 0);
    pa(`SMPG_ADDR_SPD_LIMIT, 32'h3c, 1, 0, 0);
    $display("test registers done");
    startMove(100);
    @(negedge core_clk);
    check({31'h0, motionComplete}, 32'h0, "complete dropped");
    for (i = 0; i < 200 && refSpeed === 0; i++) @(negedge core_clk);
    check(refSpeed, 30000, "start speed step");
    check(32'(profilePhase), 32'(smpg_pkg::ST_ACCEL), "accel phase");
    nextStep(d);
    check(d, 600, "accel step");
    pa(`SMPG_ADDR_JERK, 32'h4, 1, 1, 0);
    for (i = 0; i < 3000 && profilePhase !== smpg_pkg::ST_CRUISE; i++)
      @(negedge core_clk);
    repeat (2) @(negedge core_clk);
    check(refSpeed, 60000, "clamped speed");
    startMove(0);
    nextStep(d);
    check(d, -750, "decel step");
    for (i = 0; i < 3000 && refSpeed !== 0; i++) begin
      last = refSpeed;
      @(negedge core_clk);
    end
    check(last, 30000, "stop speed step");
    waitDone(100);
    $display("test linear_move done");
    pa(`SMPG_ADDR_SPD_LIMIT, 32'hbb8, 1, 0, 0);
    pa(`SMPG_ADDR_SHAPE, 32'hffff, 1, 0, 0);
    startMove(600);
    for (i = 0; i < 20000 && refSpeed < 520000; i++) @(negedge core_clk);
    nextStep(d);
    check(d, 525, "reduced accel step");
    moveCmd.quickStop = 1'b1;
    repeat (40) @(negedge core_clk);
    nextStep(d);
    check(d, -750, "quick stop step");
    waitDone(20000);
    moveCmd.quickStop = 1'b0;
    $display("test optimised_move done");
    t0 = travel_r;
    @(negedge core_clk);
    moveCmd = '{40'sd3000000, 16'sd60, smpg_pkg::MODE_PROF_POS, 1'b1, 1'b0};
    @(negedge core_clk);
    moveCmd.start = 1'b0;
    waitDone(6000);
    check(32'(travel_r - t0), 32'd60000000, "position travel");
    $display("test position_move done");
    pa(`SMPG_ADDR_JERK, 32'h4, 1, 0, 0);
    t0 = travel_r;
    startMove(-100);
    for (i = 0; i < 200 && refSpeed === 0; i++) @(negedge core_clk);
    check({31'h0, refSpeed[31]}, 32'h1, "reverse direction");
    repeat (200) @(negedge core_clk);
    startMove(0);
    for (i = 0; i < 3000 && profilePhase !== smpg_pkg::ST_IDLE; i++)
      @(negedge core_clk);
    check({31'h0, motionComplete}, 32'h0, "filter still draining");
    waitDone(400);
    check({31'h0, travel_r < t0}, 32'h1, "reverse travel");
    $display("test jerk_reverse done");
    repeat (3) @(negedge core_clk);
    final_report();
  end
endmodule : test_stepper_motion_profile_generator
